/* design/sadc_regs.svh */
// constants for the serial converter frame link: positions, counts, timing
`ifndef SADC_REGS_SVH
`define SADC_REGS_SVH

// ============================================================
// frame layout
`define SADC_FRAME_CLKS      5'd16
`define SADC_LEAD_ZEROS      5'd3
`define SADC_DATA_BITS       5'd8
`define SADC_DATA_FIRST_FALL 5'd4
`define SADC_DATA_LAST_FALL  5'd11
`define SADC_SAR_FIRST_RISE  5'd2
`define SADC_SAR_LAST_RISE   5'd9
`define SADC_TRACK_RISE      5'd13
`define SADC_RESULT_MSB      12
`define SADC_RESULT_LSB      5

// ============================================================
// reset values
`define SADC_RST_CODE        8'h00
`define SADC_RST_CNT         5'h00
`define SADC_RST_PIN_HIGH    1'b1
`define SADC_RST_PIN_LOW     1'b0

// ============================================================
// timing
`define SADC_CLK_NS          25
`define SADC_SCLK_PERIOD_NS  200
`define SADC_ACQ_NS          350
`define SADC_QUIET_NS        50
`define SADC_SCLK_HALF_CYC   (`SADC_SCLK_PERIOD_NS / 2 / `SADC_CLK_NS)
`define SADC_ACQ_CYC         ((`SADC_ACQ_NS + `SADC_CLK_NS - 1) / `SADC_CLK_NS)
`define SADC_QUIET_CYC       ((`SADC_QUIET_NS + `SADC_CLK_NS - 1) / `SADC_CLK_NS)
`define SADC_GAP_CYC         ((`SADC_ACQ_CYC > `SADC_QUIET_CYC) ? `SADC_ACQ_CYC : `SADC_QUIET_CYC)

`endif

/* design/sadc_pkg.sv */
// types shared by both ends of the serial converter link
`default_nettype none

package sadc_pkg;

   // ============================================================
   // device frame states
   typedef enum logic [2:0] {
      SADC_DEV_IDLE  = 3'b001,
      SADC_DEV_FRAME = 3'b010,
      SADC_DEV_DONE  = 3'b100
   } sadc_dev_state_t;

   // ============================================================
   // host sequencer states
   typedef enum logic [4:0] {
      SADC_HOST_IDLE = 5'b00001,
      SADC_HOST_SEL  = 5'b00010,
      SADC_HOST_LOW  = 5'b00100,
      SADC_HOST_HIGH = 5'b01000,
      SADC_HOST_GAP  = 5'b10000
   } sadc_host_state_t;

endpackage : sadc_pkg

`default_nettype wire

/* design/sadc_link_if.sv */
// three-wire link between the converter end and the host end
`default_nettype none

interface sadc_link_if;
   logic sclk;
   logic cs_n;
   logic serial_result_out_o;
   logic serial_result_out_oe;
   wire  serial_result_out;

   // ============================================================
   // pin resolution
   // no tri-state inside the chip: a released pin reads as its pull-up level
   assign serial_result_out = serial_result_out_oe ? serial_result_out_o : 1'b1;

   modport device (
      input  sclk,
      input  cs_n,
      output serial_result_out_o,
      output serial_result_out_oe
   );

   modport host (
      output sclk,
      output cs_n,
      input  serial_result_out
   );
endinterface : sadc_link_if

`default_nettype wire

/* design/sadc_host.sv */
// host end: makes select and serial clock, reads one 16-clock frame per request
`default_nettype none
`include "sadc_regs.svh"

module sadc_host
   import sadc_pkg::*;
#(
   parameter int unsigned HALF_CYC = `SADC_SCLK_HALF_CYC,
   parameter int unsigned GAP_CYC  = `SADC_GAP_CYC
) (
   input  wire logic       core_clk,
   input  wire logic       rst,
   sadc_link_if.host       link,
   input  wire logic       start_req,
   output logic            busy_q,
   output logic [7:0]      result_q,
   output logic            result_valid_q
);

   // ============================================================
   // pin drivers and data synchroniser
   logic             sclk_q;
   logic             cs_n_q;
   logic             sdo_s1_q;
   logic             sdo_s2_q;
   sadc_host_state_t state_q;
   logic [15:0]      cnt_q;
   logic [4:0]       bits_q;
   logic [15:0]      shift_q;
   logic             half_done;
   logic             gap_done;

   assign link.sclk = sclk_q;
   assign link.cs_n = cs_n_q;
   assign half_done = (cnt_q == 16'(HALF_CYC - 1));
   assign gap_done  = (cnt_q == 16'(GAP_CYC - 1));

   always_ff @(posedge core_clk) begin
      if (rst) begin
         sdo_s1_q <= `SADC_RST_PIN_LOW;
         sdo_s2_q <= `SADC_RST_PIN_LOW;
      end else begin
         sdo_s1_q <= link.serial_result_out;
         sdo_s2_q <= sdo_s1_q;
      end
   end

   // ============================================================
   // frame sequencer
   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_q        <= SADC_HOST_IDLE;
         sclk_q         <= `SADC_RST_PIN_HIGH;
         cs_n_q         <= `SADC_RST_PIN_HIGH;
         cnt_q          <= 16'h0000;
         bits_q         <= `SADC_RST_CNT;
         shift_q        <= 16'h0000;
         busy_q         <= 1'b0;
         result_q       <= `SADC_RST_CODE;
         result_valid_q <= 1'b0;
      end else begin
         result_valid_q <= 1'b0;
         case (state_q)
            SADC_HOST_IDLE: begin
               cnt_q <= 16'h0000;
               if (start_req) begin
                  cs_n_q  <= 1'b0;
                  busy_q  <= 1'b1;
                  bits_q  <= `SADC_RST_CNT;
                  state_q <= SADC_HOST_SEL;
               end
            end
            SADC_HOST_SEL: begin
               cnt_q <= half_done ? 16'h0000 : cnt_q + 16'h0001;
               if (half_done) begin
                  sclk_q  <= 1'b0;
                  bits_q  <= bits_q + 5'd1;
                  state_q <= SADC_HOST_LOW;
               end
            end
            SADC_HOST_LOW: begin
               cnt_q <= half_done ? 16'h0000 : cnt_q + 16'h0001;
               if (half_done) begin
                  sclk_q  <= 1'b1;
                  state_q <= SADC_HOST_HIGH;
               end
            end
            SADC_HOST_HIGH: begin
               cnt_q <= half_done ? 16'h0000 : cnt_q + 16'h0001;
               if (half_done) begin
                  // pin already released after the last fall, so mask it
                  shift_q <= {shift_q[14:0], sdo_s2_q & (bits_q != `SADC_FRAME_CLKS)};
                  if (bits_q == `SADC_FRAME_CLKS) begin
                     cs_n_q  <= 1'b1;
                     state_q <= SADC_HOST_GAP;
                  end else begin
                     sclk_q  <= 1'b0;
                     bits_q  <= bits_q + 5'd1;
                     state_q <= SADC_HOST_LOW;
                  end
               end
            end
            SADC_HOST_GAP: begin
               cnt_q <= gap_done ? 16'h0000 : cnt_q + 16'h0001;
               if (gap_done) begin
                  result_q       <= shift_q[`SADC_RESULT_MSB:`SADC_RESULT_LSB];
                  result_valid_q <= 1'b1;
                  busy_q         <= 1'b0;
                  state_q        <= SADC_HOST_IDLE;
               end
            end
            default: begin
               state_q <= SADC_HOST_IDLE;
            end
         endcase
      end
   end

endmodule : sadc_host

`default_nettype wire

/* design/sadc_device.sv */
// converter end: samples on select fall, steps conversion and shifts the frame on the host clock
`default_nettype none
`include "sadc_regs.svh"

module sadc_device
   import sadc_pkg::*;
(
   input  wire logic       core_clk,
   input  wire logic       rst,
   sadc_link_if.device     link,
   input  wire logic [8:0] analog_level,
   output logic            tracking_q,
   output logic            converting_q,
   output logic [7:0]      result_q
);

   // ============================================================
   // pin synchronisers
   logic            cs_s1_q;
   logic            cs_s2_q;
   logic            cs_s3_q;
   logic            sclk_s1_q;
   logic            sclk_s2_q;
   logic            sclk_s3_q;
   logic            cs_fall;
   logic            cs_rise;
   logic            sclk_rise;
   logic            sclk_fall;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         cs_s1_q   <= `SADC_RST_PIN_HIGH;
         cs_s2_q   <= `SADC_RST_PIN_HIGH;
         cs_s3_q   <= `SADC_RST_PIN_HIGH;
         sclk_s1_q <= `SADC_RST_PIN_HIGH;
         sclk_s2_q <= `SADC_RST_PIN_HIGH;
         sclk_s3_q <= `SADC_RST_PIN_HIGH;
      end else begin
         cs_s1_q   <= link.cs_n;
         cs_s2_q   <= cs_s1_q;
         cs_s3_q   <= cs_s2_q;
         sclk_s1_q <= link.sclk;
         sclk_s2_q <= sclk_s1_q;
         sclk_s3_q <= sclk_s2_q;
      end
   end

   // edges only from the second stage on, never the first
   assign cs_fall   = ~cs_s2_q & cs_s3_q;
   assign cs_rise   = cs_s2_q & ~cs_s3_q;
   assign sclk_rise = sclk_s2_q & ~sclk_s3_q;
   assign sclk_fall = ~sclk_s2_q & sclk_s3_q;

   // ============================================================
   // frame state and edge counters
   sadc_dev_state_t state_q;
   logic [4:0]      rise_cnt_q;
   logic [4:0]      fall_cnt_q;
   logic [4:0]      rise_next;
   logic [4:0]      fall_next;
   logic            in_frame;

   assign rise_next = rise_cnt_q + 5'd1;
   assign fall_next = fall_cnt_q + 5'd1;
   assign in_frame  = (state_q == SADC_DEV_FRAME);

   always_ff @(posedge core_clk) begin
      if (rst) begin
         state_q    <= SADC_DEV_IDLE;
         rise_cnt_q <= `SADC_RST_CNT;
         fall_cnt_q <= `SADC_RST_CNT;
      end else begin
         case (state_q)
            SADC_DEV_IDLE: begin
               if (cs_fall) begin
                  rise_cnt_q <= `SADC_RST_CNT;
                  fall_cnt_q <= `SADC_RST_CNT;
                  state_q    <= SADC_DEV_FRAME;
               end
            end
            SADC_DEV_FRAME: begin
               if (cs_rise) begin
                  state_q <= SADC_DEV_IDLE;
               end else begin
                  if (sclk_rise) begin
                     rise_cnt_q <= rise_next;
                  end
                  if (sclk_fall) begin
                     fall_cnt_q <= fall_next;
                     if (fall_next == `SADC_FRAME_CLKS) begin
                        state_q <= SADC_DEV_DONE;
                     end
                  end
               end
            end
            SADC_DEV_DONE: begin
               // select idled low after the frame: wait for it to rise
               if (cs_rise) begin
                  state_q <= SADC_DEV_IDLE;
               end
            end
            default: begin
               state_q <= SADC_DEV_IDLE;
            end
         endcase
      end
   end

   // ============================================================
   // track and hold, quantiser
   logic [9:0] level_rounded;
   logic [7:0] level_code;
   logic [7:0] held_q;

   // codes step midway between LSBs; top half step saturates
   assign level_rounded = {1'b0, analog_level} + 10'h001;
   assign level_code    = level_rounded[9] ? 8'hFF : level_rounded[8:1];

   always_ff @(posedge core_clk) begin
      if (rst) begin
         tracking_q <= 1'b1;
         held_q     <= `SADC_RST_CODE;
      end else if (state_q == SADC_DEV_IDLE && cs_fall) begin
         tracking_q <= 1'b0;
         held_q     <= level_code;
      end else if (in_frame && !cs_rise && sclk_rise && rise_next == `SADC_TRACK_RISE) begin
         tracking_q <= 1'b1;
      end else if (cs_rise) begin
         // an aborted frame still lets the input track again
         tracking_q <= 1'b1;
      end
   end

   // ============================================================
   // successive approximation, one bit per rising edge
   logic [7:0] sar_q;
   logic [4:0] sar_idx;
   logic [7:0] sar_trial;

   assign sar_idx   = `SADC_SAR_LAST_RISE - rise_next;
   assign sar_trial = sar_q | (8'h01 << sar_idx[2:0]);

   always_ff @(posedge core_clk) begin
      if (rst) begin
         sar_q        <= `SADC_RST_CODE;
         converting_q <= 1'b0;
         result_q     <= `SADC_RST_CODE;
      end else if (state_q == SADC_DEV_IDLE && cs_fall) begin
         sar_q        <= `SADC_RST_CODE;
         converting_q <= 1'b1;
      end else if (in_frame && !cs_rise && sclk_rise) begin
         if (rise_next >= `SADC_SAR_FIRST_RISE && rise_next <= `SADC_SAR_LAST_RISE) begin
            sar_q <= (sar_trial <= held_q) ? sar_trial : sar_q;
         end
         if (rise_next == `SADC_TRACK_RISE) begin
            converting_q <= 1'b0;
            result_q     <= sar_q;
         end
      end else if (cs_rise) begin
         converting_q <= 1'b0;
      end
   end

   // ============================================================
   // serial output shifter
   logic sdo_q;
   logic sdo_oe_q;

   assign link.serial_result_out_o  = sdo_q;
   assign link.serial_result_out_oe = sdo_oe_q;

   always_ff @(posedge core_clk) begin
      if (rst) begin
         sdo_q    <= `SADC_RST_PIN_LOW;
         sdo_oe_q <= 1'b0;
      end else if (cs_s2_q) begin
         // released on select rise and held released while high
         sdo_q    <= 1'b0;
         sdo_oe_q <= 1'b0;
      end else if (state_q == SADC_DEV_IDLE && cs_fall) begin
         sdo_q    <= 1'b0;
         sdo_oe_q <= 1'b1;
      end else if (in_frame && sclk_fall) begin
         if (fall_next == `SADC_FRAME_CLKS) begin
            sdo_q    <= 1'b0;
            sdo_oe_q <= 1'b0;
         end else if (fall_next >= `SADC_DATA_FIRST_FALL && fall_next <= `SADC_DATA_LAST_FALL) begin
            sdo_q <= sar_q[3'(`SADC_DATA_LAST_FALL - fall_next)];
         end else begin
            sdo_q <= 1'b0;
         end
      end
   end

endmodule : sadc_device

`default_nettype wire

/* verification/sadc_link_sva.sv */
// assertions on the three-wire converter link, seen from select, clock and the converter's data driver and its enable
`default_nettype none

// ============================================================
// link checker
module sadc_link_sva (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic serial_result_out_o,
   input wire logic serial_result_out_oe
);
   timeunit 1ns;
   timeprecision 100ps;

   logic       sclk_q;
   logic [4:0] fall_q;
   logic [4:0] rise_q;
   logic [7:0] hi_q;
   logic [7:0] acq_q;
   wire        sfall = sclk_q & ~sclk;
   wire        srise = ~sclk_q & sclk;

   // ============================================================
   // helper counters
   always_ff @(posedge core_clk) begin
      sclk_q <= rst ? 1'b1 : sclk;
   end

   // edge counts restart at every select fall, like the device's own
   always_ff @(posedge core_clk) begin
      if (rst || cs_n) begin
         fall_q <= 5'h00;
         rise_q <= 5'h00;
      end else begin
         fall_q <= fall_q + {4'h0, sfall};
         rise_q <= rise_q + {4'h0, srise};
      end
   end

   // saturating spans; preset full so the first frame after reset passes
   always_ff @(posedge core_clk) begin
      if (rst) begin
         hi_q <= 8'hFF;
      end else if (!cs_n) begin
         hi_q <= 8'h00;
      end else if (hi_q != 8'hFF) begin
         hi_q <= hi_q + 8'h01;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         acq_q <= 8'hFF;
      end else if (srise && rise_q == 5'h0C && !cs_n) begin
         acq_q <= 8'h00;
      end else if (acq_q != 8'hFF) begin
         acq_q <= acq_q + 8'h01;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   // ============================================================
   // assertions
   chk_oe_on_select: assert property (
      $fell(cs_n) |-> ##2 !serial_result_out_oe ##1 (serial_result_out_oe && !serial_result_out_o))
      else $error("no driven zero three cycles after select fall");
   chk_release_deselect: assert property (
      $rose(cs_n) |-> ##3 !serial_result_out_oe)
      else $error("output still driven after select rise");
   chk_release_after16: assert property (
      (sfall && fall_q == 5'h0F && !cs_n) |-> ##2 serial_result_out_oe ##1 !serial_result_out_oe)
      else $error("output not released at sixteenth fall");
   chk_idle_released: assert property (
      cs_n [*4] |-> !serial_result_out_oe)
      else $error("output driven while deselected");
   chk_data_on_fall: assert property (
      (serial_result_out_oe && $past(serial_result_out_oe) && $changed(serial_result_out_o)) |-> $past(sfall, 3))
      else $error("data changed away from a clock fall");
   chk_lead_zeros: assert property (
      (serial_result_out_oe && fall_q <= 5'h03) |-> !serial_result_out_o)
      else $error("leading bit not zero");
   chk_trail_zeros: assert property (
      (serial_result_out_oe && $past(fall_q, 3) >= 5'h0C) |-> !serial_result_out_o)
      else $error("trailing bit not zero");
   chk_sixteen_clocks: assert property (
      $rose(cs_n) |-> (fall_q == 5'h10 && rise_q == 5'h10))
      else $error("frame not sixteen clocks");
   chk_first_fall_pad: assert property (
      $fell(cs_n) |-> sclk [*4] ##1 !sclk)
      else $error("first clock fall not half a period after select");
   chk_acq_spacing: assert property (
      $fell(cs_n) |-> acq_q >= 8'h0D)
      else $error("acquisition span too short");
   chk_quiet_gap: assert property (
      $fell(cs_n) |-> hi_q >= 8'h02)
      else $error("quiet time too short");

   cov_full_frame: cover property ($rose(cs_n) && fall_q == 5'h10);
   cov_last_fall: cover property (sfall && fall_q == 5'h0F && !cs_n);
   cov_select: cover property ($fell(cs_n));
endmodule : sadc_link_sva

`default_nettype wire

/* verification/tb_serial_adc_frame_interface.sv */
// self-checking bench: host end and converter end joined over the link
`default_nettype none

// ============================================================
// bench top
module tb_serial_adc_frame_interface;
   timeunit 1ns;
   timeprecision 100ps;

   logic        core_clk     = 1'b0;
   logic        rst          = 1'b1;
   logic        start_req    = 1'b0;
   logic [8:0]  analog_level = 9'h000;
   logic        busy_q;
   logic        result_valid_q;
   logic        tracking_q;
   logic        converting_q;
   logic [7:0]  host_res;
   logic [7:0]  dev_res;
   logic [15:0] cap_q        = 16'h0000;
   logic        trk13        = 1'b0;
   logic        trk14        = 1'b0;
   int          rise_n       = 0;
   int          err_total    = 0;
   int          total_checks = 0;
   logic [8:0]  levels [8]   = '{9'h000, 9'h001, 9'h002, 9'h0FF, 9'h100, 9'h1FE, 9'h1FF, 9'h155};

   sadc_link_if link_if ();

   sadc_host sadc_host_i (.core_clk(core_clk), .rst(rst), .link(link_if), .start_req(start_req),
      .busy_q(busy_q), .result_q(host_res), .result_valid_q(result_valid_q));

   sadc_device sadc_device_i (.core_clk(core_clk), .rst(rst), .link(link_if), .analog_level(analog_level),
      .tracking_q(tracking_q), .converting_q(converting_q), .result_q(dev_res));

   sadc_link_sva sadc_link_sva_i (.core_clk(core_clk), .rst(rst), .sclk(link_if.sclk), .cs_n(link_if.cs_n),
      .serial_result_out_o(link_if.serial_result_out_o), .serial_result_out_oe(link_if.serial_result_out_oe));

   always #12.5 core_clk = ~core_clk;

   // ============================================================
   // wire monitor: receiver view, one bit per clock rise
   // preset the track samples to failing values so a missed rise is caught
   always @(negedge link_if.cs_n) begin
      rise_n = 0;
      trk13  = 1'b1;
      trk14  = 1'b0;
   end
   always @(posedge link_if.sclk) begin
      if (link_if.cs_n === 1'b0) begin
         cap_q = {cap_q[14:0], link_if.serial_result_out};
         rise_n = rise_n + 1;
         #1;
         if (rise_n == 13) trk13 = tracking_q;
         if (rise_n == 14) trk14 = tracking_q;
      end
   end

   // ============================================================
   // helpers
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   function automatic logic [7:0] exp_code(input logic [8:0] lvl);
      logic [9:0] v;
      v = ({1'b0, lvl} + 10'h001) >> 1;
      return (v > 10'h0FF) ? 8'hFF : v[7:0];
   endfunction : exp_code

   // late level is applied once the sample is held; it must not reach the code
   task automatic run_conv(input logic [8:0] lvl, input logic [8:0] lvl_late);
      int         n;
      logic [7:0] e;
      e = exp_code(lvl);
      analog_level = lvl;
      start_req = 1'b1;
      @(posedge core_clk);
      #2;
      start_req = 1'b0;
      check({15'h0000, busy_q}, 16'h0001);
      n = 0;
      while (converting_q !== 1'b1 && n < 20) begin
         @(posedge core_clk);
         #2;
         n++;
      end
      check({15'h0000, converting_q}, 16'h0001);
      check({15'h0000, tracking_q}, 16'h0000);
      analog_level = lvl_late;
      n = 0;
      while (result_valid_q !== 1'b1 && n < 400) begin
         @(posedge core_clk);
         #2;
         n++;
      end
      check({14'h0000, result_valid_q, busy_q}, 16'h0002);
      check({8'h00, host_res}, {8'h00, e});
      check({8'h00, dev_res}, {8'h00, e});
      check(cap_q, {3'b000, e, 4'h0, 1'b1});
      check({14'h0000, trk13, trk14}, 16'h0001);
      check({15'h0000, converting_q}, 16'h0000);
      $display("test level %h done", lvl);
   endtask : run_conv

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : print_verdict

   // ============================================================
   // sequence: back-to-back frames over code boundaries
   initial begin
      repeat (6) @(posedge core_clk);
      #2;
      rst = 1'b0;
      check({15'h0000, link_if.serial_result_out_oe}, 16'h0000);
      foreach (levels[i]) run_conv(levels[i], levels[i]);
      run_conv(9'h0AA, 9'h1FF);
      print_verdict();
   end

   // whole run is about 33 us; cut a hang well beyond that
   initial begin
      #150000;
      err_total++;
      print_verdict();
   end
endmodule : tb_serial_adc_frame_interface

`default_nettype wire
